// ### rtl/slu_shift_unit.sv
// Execution-stage shift-left unit with four accumulator pairs
`timescale 1ns/1ps

module slu_shift_unit
    import slu_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    // Issue from the pipeline
    input wire logic valid_i,
    input wire slu_op_t op_i,
    input wire logic [WORD_W-1:0] operand_reg_i,
    input wire logic [WORD_W-1:0] shift_source_reg_i,
    input wire logic [HALF_CNT_W-1:0] imm_shift_count_i,
    input wire logic [PAIR_SEL_W-1:0] pair_select_i,
    // Direct accumulator load from the pipeline
    input wire logic acc_wr_en_i,
    input wire logic [PAIR_SEL_W-1:0] acc_wr_sel_i,
    input wire logic [WORD_W-1:0] acc_wr_upper_i,
    input wire logic [WORD_W-1:0] acc_wr_bottom_i,
    // Accumulator read port
    input wire logic [PAIR_SEL_W-1:0] acc_rd_sel_i,
    output logic [WORD_W-1:0] accum_upper_word_o,
    output logic [WORD_W-1:0] accum_bottom_word_o,
    // Destination word result
    output logic [WORD_W-1:0] result_o,
    output logic result_valid_o,
    output logic acc_done_o,
    // Control word overflow interface
    input wire logic ovf_clear_i,
    output logic ovf_set_o,
    output logic [WORD_W-1:0] ctrl_set_mask_o,
    output logic ovf_sticky_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ACC_PAIRS-1:0][ACC_W-1:0] acc;
        logic [WORD_W-1:0] result;
        logic result_valid;
        logic acc_done;
        logic ovf_pulse;
        logic ovf_sticky;
        logic [WORD_W-1:0] rd_upper;
        logic [WORD_W-1:0] rd_bottom;
    } slu_state_t;

    slu_state_t state_reg;
    slu_state_t state_next;

    // ----------------------------------------------------------------
    // Accumulator shift function
    // ----------------------------------------------------------------
    // Negating the count gives 32 for the most negative value, which
    // the six-bit magnitude still holds, so no extra bit is needed.
    function automatic logic [ACC_W-1:0] acc_shift(
        input logic [ACC_W-1:0] value,
        input logic [ACC_CNT_W-1:0] count
    );
        logic [ACC_CNT_W-1:0] mag;
        logic [ACC_W-1:0] res;
        mag = count[ACC_CNT_W-1] ? ACC_CNT_W'(-count) : count;
        if (mag == '0) begin
            res = value;
        end else if (count[ACC_CNT_W-1]) begin
            res = value << mag;
        end else begin
            res = value >> mag;
        end
        return res;
    endfunction : acc_shift

    // ----------------------------------------------------------------
    // Operation decode
    // ----------------------------------------------------------------
    logic is_acc_op;
    logic is_half_op;
    logic is_byte_op;
    logic half_sat;
    logic half_var;
    logic [HALF_CNT_W-1:0] half_count;
    logic [BYTE_CNT_W-1:0] byte_count;
    logic [ACC_CNT_W-1:0] acc_count;

    // Unknown encodings decode to nothing rather than trapping
    always_comb begin
        is_acc_op = 1'b0;
        is_half_op = 1'b0;
        is_byte_op = 1'b0;
        half_sat = 1'b0;
        half_var = 1'b0;
        case (op_i)
            SLU_ACCUM_VARIABLE_SHIFT: begin
                is_acc_op = 1'b1;
            end
            SLU_PAIR_HALF_FIXED_SHIFT_LEFT: begin
                is_half_op = 1'b1;
            end
            SLU_PAIR_HALF_FIXED_SHIFT_LEFT_SAT: begin
                is_half_op = 1'b1;
                half_sat = 1'b1;
            end
            SLU_QUAD_BYTE_FIXED_SHIFT_LEFT: begin
                is_byte_op = 1'b1;
            end
            SLU_PAIR_HALF_VAR_SHIFT_LEFT: begin
                is_half_op = 1'b1;
                half_var = 1'b1;
            end
            SLU_PAIR_HALF_VAR_SHIFT_LEFT_SAT: begin
                is_half_op = 1'b1;
                half_var = 1'b1;
                half_sat = 1'b1;
            end
            default: begin
                is_acc_op = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Count selection
    // ----------------------------------------------------------------
    // Upper bits of the source register are simply never looked at
    assign acc_count = shift_source_reg_i[ACC_CNT_W-1:0];
    assign half_count = half_var ? shift_source_reg_i[HALF_CNT_W-1:0]
                                 : imm_shift_count_i;
    assign byte_count = imm_shift_count_i[BYTE_CNT_W-1:0];

    // ----------------------------------------------------------------
    // Halfword lanes
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] half_result;
    logic [HALF_LANES-1:0] half_ovf;

    for (genvar h = 0; h < HALF_LANES; h++) begin : g_half
        slu_half_lane u_half (
            .elem_i(operand_reg_i[h*HALF_W +: HALF_W]),
            .count_i(half_count),
            .sat_i(half_sat),
            .elem_o(half_result[h*HALF_W +: HALF_W]),
            .ovf_o(half_ovf[h])
        );
    end

    // ----------------------------------------------------------------
    // Byte lanes
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] byte_result;
    logic [BYTE_LANES-1:0] byte_ovf;

    for (genvar b = 0; b < BYTE_LANES; b++) begin : g_byte
        slu_byte_lane u_byte (
            .elem_i(operand_reg_i[b*BYTE_W +: BYTE_W]),
            .count_i(byte_count),
            .elem_o(byte_result[b*BYTE_W +: BYTE_W]),
            .ovf_o(byte_ovf[b])
        );
    end

    // ----------------------------------------------------------------
    // Overflow merge
    // ----------------------------------------------------------------
    logic any_ovf;

    // Any lane of the active element kind raises the flag
    always_comb begin
        any_ovf = 1'b0;
        if (valid_i && is_half_op) begin
            any_ovf = |half_ovf;
        end else if (valid_i && is_byte_op) begin
            any_ovf = |byte_ovf;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [ACC_W-1:0] acc_sel;
    logic [ACC_W-1:0] acc_new;

    assign acc_sel = state_reg.acc[pair_select_i];
    assign acc_new = acc_shift(acc_sel, acc_count);

    // A shift to the same pair as a direct load in one cycle wins,
    // since it is the later instruction in the pipeline order assumed.
    always_comb begin
        state_next = state_reg;
        state_next.result_valid = 1'b0;
        state_next.acc_done = 1'b0;
        state_next.ovf_pulse = any_ovf;
        if (acc_wr_en_i) begin
            state_next.acc[acc_wr_sel_i] = {acc_wr_upper_i, acc_wr_bottom_i};
        end
        if (valid_i && is_acc_op) begin
            state_next.acc[pair_select_i] = acc_new;
            state_next.acc_done = 1'b1;
        end
        if (valid_i && is_half_op) begin
            state_next.result = half_result;
            state_next.result_valid = 1'b1;
        end
        if (valid_i && is_byte_op) begin
            state_next.result = byte_result;
            state_next.result_valid = 1'b1;
        end
        // Set wins over a clear from the control-word logic
        if (any_ovf) begin
            state_next.ovf_sticky = 1'b1;
        end else if (ovf_clear_i) begin
            state_next.ovf_sticky = 1'b0;
        end
        // Read port shows the pair as it stands after this cycle
        state_next.rd_upper = state_next.acc[acc_rd_sel_i][ACC_W-1:WORD_W];
        state_next.rd_bottom = state_next.acc[acc_rd_sel_i][WORD_W-1:0];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg.acc <= {ACC_PAIRS{ACC_RESET}};
            state_reg.result <= WORD_RESET;
            state_reg.result_valid <= 1'b0;
            state_reg.acc_done <= 1'b0;
            state_reg.ovf_pulse <= 1'b0;
            state_reg.ovf_sticky <= 1'b0;
            state_reg.rd_upper <= WORD_RESET;
            state_reg.rd_bottom <= WORD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Overflow leaves the unit only as flag bits, never as a trap
    assign result_o = state_reg.result;
    assign result_valid_o = state_reg.result_valid;
    assign acc_done_o = state_reg.acc_done;
    assign accum_upper_word_o = state_reg.rd_upper;
    assign accum_bottom_word_o = state_reg.rd_bottom;
    assign ovf_set_o = state_reg.ovf_pulse;
    assign ctrl_set_mask_o = state_reg.ovf_pulse ? OVF_SET_MASK : WORD_RESET;
    assign ovf_sticky_o = state_reg.ovf_sticky;

endmodule : slu_shift_unit

// ### rtl/slu_pkg.sv
// Shared constants and types for the SIMD shift-left unit
//
// Behaviour
// - The accumulator shift joins upper and lower words of the chosen pair, shifts the 64-bit value logically and writes it back to the same pair.
// - The accumulator shift count is the low six bits of the shift source register; higher bits are ignored.
// - That six-bit count is signed: positive shifts right up to 31 with zero fill, negative shifts left up to 32 with zero fill.
// - The pair select runs from 0 to 3, pair 0 being the original upper/lower result pair.
// - The fixed halfword shift moves each 16-bit element left on its own, zero-filling low bits, into the matching destination halfword.
// - In saturating halfword forms an overflowing element becomes 0x7FFF if its sign was 0, or 0x8000 if its sign was 1.
// - Halfword overflow is when the sign bit and the bits shifted out below it are not all zeros and not all ones.
// - Only saturating forms clamp; non-saturating forms write the truncated shift yet still report overflow.
// - Any element overflow or saturation in these shifts writes one into bit 22 of the control word overflow bits.
// - The quad-byte shift moves each of four bytes left by the three-bit immediate, zero-filling, into the matching byte lane.
// - Byte overflow is when the top bit or any bit shifted out below it is one, compared only against zero.
// - Variable halfword shifts take an unsigned count from the low four bits of the shift source register.
// - Variable halfword shifts use one count for both halves and behave as the fixed forms, saturating or not.
// - No shift raises a data-dependent exception; overflow shows only through the sticky bit.

package slu_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int ACC_W = 64;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int ACC_PAIRS = 4;
    localparam int PAIR_SEL_W = 2;
    localparam int ACC_CNT_W = 6;
    localparam int HALF_CNT_W = 4;
    localparam int BYTE_CNT_W = 3;
    localparam int HALF_LANES = 2;
    localparam int BYTE_LANES = 4;

    // ----------------------------------------------------------------
    // Control word overflow bit and saturation values
    // ----------------------------------------------------------------
    localparam int OVF_BIT_POS = 22;
    localparam logic [WORD_W-1:0] OVF_SET_MASK = 32'h0040_0000;
    localparam logic [HALF_W-1:0] HALF_SAT_POS = 16'h7FFF;
    localparam logic [HALF_W-1:0] HALF_SAT_NEG = 16'h8000;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [ACC_W-1:0] ACC_RESET = 64'h0000_0000_0000_0000;
    localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Operations accepted from the pipeline
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SLU_ACCUM_VARIABLE_SHIFT,
        SLU_PAIR_HALF_FIXED_SHIFT_LEFT,
        SLU_PAIR_HALF_FIXED_SHIFT_LEFT_SAT,
        SLU_QUAD_BYTE_FIXED_SHIFT_LEFT,
        SLU_PAIR_HALF_VAR_SHIFT_LEFT,
        SLU_PAIR_HALF_VAR_SHIFT_LEFT_SAT
    } slu_op_t;

endpackage : slu_pkg

// ### rtl/slu_half_lane.sv
// One halfword lane of the left shifter with optional saturation
`timescale 1ns/1ps

module slu_half_lane
    import slu_pkg::*;
(
    input wire logic [HALF_W-1:0] elem_i,
    input wire logic [HALF_CNT_W-1:0] count_i,
    input wire logic sat_i,
    output logic [HALF_W-1:0] elem_o,
    output logic ovf_o
);

    logic [HALF_CNT_W-1:0] top_amt;
    logic [HALF_W-1:0] top_bits;
    logic [HALF_W-1:0] shifted;

    // ----------------------------------------------------------------
    // Shift and overflow check
    // ----------------------------------------------------------------
    // Arithmetic shift keeps sign plus shifted-out bits, sign extended
    always_comb begin
        top_amt = HALF_CNT_W'(HALF_W - 1) - count_i;
        top_bits = HALF_W'($signed(elem_i) >>> top_amt);
        shifted = elem_i << count_i;
        ovf_o = (count_i != '0) && (top_bits != '0) && (top_bits != '1);
        if (sat_i && ovf_o) begin
            elem_o = elem_i[HALF_W-1] ? HALF_SAT_NEG : HALF_SAT_POS;
        end else begin
            elem_o = shifted;
        end
    end

endmodule : slu_half_lane

// ### rtl/slu_byte_lane.sv
// One byte lane of the left shifter, no saturation
`timescale 1ns/1ps

module slu_byte_lane
    import slu_pkg::*;
(
    input wire logic [BYTE_W-1:0] elem_i,
    input wire logic [BYTE_CNT_W-1:0] count_i,
    output logic [BYTE_W-1:0] elem_o,
    output logic ovf_o
);

    logic [BYTE_CNT_W-1:0] top_amt;
    logic [BYTE_W-1:0] top_bits;

    // ----------------------------------------------------------------
    // Shift and overflow check
    // ----------------------------------------------------------------
    // Bytes are checked against zero only, so negative bytes flag at any non-zero count
    always_comb begin
        top_amt = BYTE_CNT_W'(BYTE_W - 1) - count_i;
        top_bits = elem_i >> top_amt;
        elem_o = elem_i << count_i;
        ovf_o = (count_i != '0) && (top_bits != '0);
    end

endmodule : slu_byte_lane

// ### verification/slu_ctrl_model.sv
// Partner model: pipeline side copy of the extension control word
`timescale 1ns/1ps

module slu_ctrl_model
    import slu_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ovf_set_i,
    input wire logic [WORD_W-1:0] set_mask_i,
    input wire logic clear_i,
    output logic [WORD_W-1:0] ctrl_word_o
);
    // Set wins over a software clear so an overflow is never lost
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_word_o <= WORD_RESET;
        end else if (ovf_set_i) begin
            ctrl_word_o <= ctrl_word_o | set_mask_i;
        end else if (clear_i) begin
            ctrl_word_o <= ctrl_word_o & ~OVF_SET_MASK;
        end
    end
endmodule : slu_ctrl_model

// ### verification/slu_assertions.sv
// Port-level checks for the shift-left unit
`timescale 1ns/1ps

module slu_assertions
    import slu_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic valid_i,
    input wire slu_op_t op_i,
    input wire logic [WORD_W-1:0] operand_reg_i,
    input wire logic [HALF_CNT_W-1:0] imm_shift_count_i,
    input wire logic ovf_clear_i,
    input wire logic [WORD_W-1:0] result_o,
    input wire logic result_valid_o,
    input wire logic acc_done_o,
    input wire logic ovf_set_o,
    input wire logic [WORD_W-1:0] ctrl_set_mask_o,
    input wire logic ovf_sticky_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // --------------------------------------------------------
    // Issue sequences
    // --------------------------------------------------------
    sequence s_lane_op;
        valid_i && op_i != SLU_ACCUM_VARIABLE_SHIFT && op_i <= SLU_PAIR_HALF_VAR_SHIFT_LEFT_SAT;
    endsequence
    sequence s_acc_op;
        valid_i && op_i == SLU_ACCUM_VARIABLE_SHIFT;
    endsequence
    sequence s_clamp_pos;
        valid_i && op_i == SLU_PAIR_HALF_FIXED_SHIFT_LEFT_SAT && imm_shift_count_i == 4'h1
            && operand_reg_i[15:14] == 2'b01;
    endsequence
    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    a_lane_answer: assert property (s_lane_op |=> result_valid_o && !acc_done_o)
        else $error("lane op gave no result pulse");
    a_acc_answer: assert property (s_acc_op |=> acc_done_o && !result_valid_o && !ovf_set_o)
        else $error("accumulator op gave wrong pulses");
    a_idle_quiet: assert property (!valid_i |=> !result_valid_o && !acc_done_o && !ovf_set_o)
        else $error("pulse without an issued op");
    a_mask_value: assert property (ctrl_set_mask_o == (ovf_set_o ? OVF_SET_MASK : WORD_RESET))
        else $error("control word set mask wrong");
    a_sticky_set: assert property (ovf_set_o |-> ovf_sticky_o)
        else $error("overflow did not set sticky bit");
    a_sticky_hold: assert property (ovf_sticky_o && !ovf_clear_i |=> ovf_sticky_o)
        else $error("sticky bit dropped without clear");
    a_sticky_clear: assert property (ovf_clear_i && !valid_i |=> !ovf_sticky_o)
        else $error("sticky bit not cleared");
    a_zero_pass: assert property (valid_i && op_i == SLU_PAIR_HALF_FIXED_SHIFT_LEFT
        && imm_shift_count_i == 4'h0 |=> result_o == $past(operand_reg_i) && !ovf_set_o)
        else $error("zero count did not pass through");
    a_clamp_pos: assert property (s_clamp_pos |=> result_o[15:0] == HALF_SAT_POS && ovf_set_o)
        else $error("positive clamp missing");
endmodule : slu_assertions

bind slu_shift_unit slu_assertions u_slu_assertions (.clk_i(clk_i), .reset_i(reset_i),
    .valid_i(valid_i), .op_i(op_i), .operand_reg_i(operand_reg_i),
    .imm_shift_count_i(imm_shift_count_i), .ovf_clear_i(ovf_clear_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .acc_done_o(acc_done_o), .ovf_set_o(ovf_set_o),
    .ctrl_set_mask_o(ctrl_set_mask_o), .ovf_sticky_o(ovf_sticky_o));

// ### verification/testbench.sv
// Self-checking bench for the shift-left unit
`timescale 1ns/1ps

module testbench;
    import slu_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic valid_i = 1'b0, wr_en = 1'b0, clr = 1'b0;
    slu_op_t op_i = SLU_ACCUM_VARIABLE_SHIFT;
    logic [31:0] opnd = 32'h0, src = 32'h0, wr_up = 32'h0, wr_bot = 32'h0;
    logic [3:0] imm = 4'h0;
    logic [1:0] pair = 2'h0, wr_sel = 2'h0, rd_sel = 2'h0;
    logic [31:0] up, bot, result, mask, ctrl_word;
    logic res_valid, acc_done, ovf_set, sticky;
    int mismatches = 0;
    int n_tests = 0;

    // 250 MHz core clock
    initial forever #2 clk_i = ~clk_i;

    slu_shift_unit dut (.clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i), .op_i(op_i),
        .operand_reg_i(opnd), .shift_source_reg_i(src), .imm_shift_count_i(imm),
        .pair_select_i(pair), .acc_wr_en_i(wr_en), .acc_wr_sel_i(wr_sel),
        .acc_wr_upper_i(wr_up), .acc_wr_bottom_i(wr_bot), .acc_rd_sel_i(rd_sel),
        .accum_upper_word_o(up), .accum_bottom_word_o(bot), .result_o(result),
        .result_valid_o(res_valid), .acc_done_o(acc_done), .ovf_clear_i(clr),
        .ovf_set_o(ovf_set), .ctrl_set_mask_o(mask), .ovf_sticky_o(sticky));

    slu_ctrl_model u_ctrl (.clk_i(clk_i), .reset_i(reset_i), .ovf_set_i(ovf_set),
        .set_mask_i(mask), .clear_i(clr), .ctrl_word_o(ctrl_word));

    // --------------------------------------------------------
    // Shared helpers
    // --------------------------------------------------------
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle issue; returns once the registered answer has landed
    task automatic issue(slu_op_t op, logic [31:0] a, logic [31:0] s, logic [3:0] i,
        logic [1:0] p);
        @(posedge clk_i);
        wr_en <= 1'b0;
        valid_i <= 1'b1;
        op_i <= op;
        opnd <= a;
        src <= s;
        imm <= i;
        pair <= p;
        @(posedge clk_i);
        valid_i <= 1'b0;
        clr <= 1'b0; // A clear held across the op ends with it
        #1;
    endtask : issue

    // Halfword reference: overflow flag on top of the lane result
    function automatic logic [16:0] half_ref(logic [15:0] a, int s, bit sat);
        logic [15:0] top;
        logic ovf;
        top = a >> (15 - s);
        ovf = (s != 0) && (top != 16'h0) && (top != 16'((17'h1 << (s + 1)) - 1));
        if (ovf && sat) return {1'b1, a[15] ? HALF_SAT_NEG : HALF_SAT_POS};
        return {ovf, 16'(a << s)};
    endfunction : half_ref

    task automatic results();
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic test_reset();
        #1;
        check("reset outputs", {result, mask}, 64'h0);
        check("reset accum", {up, bot}, ACC_RESET);
        check("reset flags", {res_valid, acc_done, ovf_set, sticky}, 64'h0);
    endtask : test_reset

    // Fixed and variable halfword forms, junk in the unused count bits
    task automatic test_half();
        slu_op_t ops[4] = '{SLU_PAIR_HALF_FIXED_SHIFT_LEFT, SLU_PAIR_HALF_FIXED_SHIFT_LEFT_SAT,
            SLU_PAIR_HALF_VAR_SHIFT_LEFT, SLU_PAIR_HALF_VAR_SHIFT_LEFT_SAT};
        logic [31:0] vals[3] = '{32'h8001_4000, 32'h0123_FEDC, 32'h7FFF_C000};
        logic [16:0] hi, lo;
        foreach (ops[k]) foreach (vals[v]) for (int c = 0; c < 16; c++) begin
            if (k >= 2) issue(ops[k], vals[v], {28'hFFF_FFFA, 4'(c)}, 4'(~c), 2'h1);
            else issue(ops[k], vals[v], 32'hFFFF_FFFF, 4'(c), 2'h1);
            hi = half_ref(vals[v][31:16], c, k[0]);
            lo = half_ref(vals[v][15:0], c, k[0]);
            check("half result", result, {hi[15:0], lo[15:0]});
            check("half flag", ovf_set, hi[16] | lo[16]);
            check("half valid", res_valid, 1'b1);
        end
    endtask : test_half

    // Byte lanes; count bit 3 set to show only three bits are used
    task automatic test_byte();
        logic [31:0] vals[2] = '{32'h7F80_013F, 32'h00FF_4001};
        logic [31:0] exp;
        logic [7:0] e;
        logic ovf;
        foreach (vals[v]) for (int c = 0; c < 8; c++) begin
            issue(SLU_QUAD_BYTE_FIXED_SHIFT_LEFT, vals[v], 32'hFFFF_FFFF, {1'b1, 3'(c)}, 2'h0);
            ovf = 1'b0;
            for (int b = 0; b < 4; b++) begin
                e = vals[v][8*b +: 8];
                exp[8*b +: 8] = e << c;
                ovf |= (c != 0) && ((e >> (7 - c)) != 8'h0);
            end
            check("byte result", result, exp);
            check("byte flag", ovf_set, ovf);
        end
    endtask : test_byte

    // Every pair, counts at zero, right 1 and 31, left 32 and 1
    task automatic test_accum();
        logic [5:0] cnts[5] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3F};
        logic [63:0] v, e;
        for (int p = 0; p < 4; p++) foreach (cnts[k]) begin
            v = {32'h8000_0001 ^ 32'(p), 32'hC3A5_0F0F};
            @(posedge clk_i);
            wr_en <= 1'b1;
            wr_sel <= 2'(p);
            wr_up <= v[63:32];
            wr_bot <= v[31:0];
            rd_sel <= 2'(p);
            issue(SLU_ACCUM_VARIABLE_SHIFT, 32'h0, {26'h2AA_AAAA, cnts[k]}, 4'h0, 2'(p));
            e = cnts[k][5] ? v << (7'd64 - cnts[k]) : v >> cnts[k];
            check("accum value", {up, bot}, e);
            check("accum done", {acc_done, ovf_set}, 2'b10);
        end
    endtask : test_accum

    // Clear, set winning over clear, then hold through a clean op
    task automatic test_sticky();
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        #1;
        check("sticky cleared", sticky, 1'b0);
        issue(SLU_PAIR_HALF_FIXED_SHIFT_LEFT_SAT, 32'h4000_0001, 32'h0, 4'h1, 2'h0);
        check("sat walk", {result, ovf_set, sticky}, {32'h7FFF_0002, 2'b11});
        issue(SLU_PAIR_HALF_FIXED_SHIFT_LEFT, 32'h0001_0001, 32'h0, 4'h1, 2'h0);
        check("sticky held", {result, ovf_set, sticky}, {32'h0002_0002, 2'b01});
        check("control word", ctrl_word, OVF_SET_MASK);
    endtask : test_sticky

    // Byte op then halfword op on consecutive edges
    task automatic test_back_to_back();
        @(posedge clk_i);
        valid_i <= 1'b1;
        op_i <= SLU_QUAD_BYTE_FIXED_SHIFT_LEFT;
        opnd <= 32'h8101_0280;
        imm <= 4'h1;
        @(posedge clk_i);
        op_i <= SLU_PAIR_HALF_FIXED_SHIFT_LEFT;
        opnd <= 32'h0003_0004;
        imm <= 4'h2;
        #1;
        check("first of pair", {result, ovf_set, res_valid}, {32'h0202_0400, 2'b11});
        @(posedge clk_i);
        valid_i <= 1'b0;
        #1;
        check("second of pair", {result, ovf_set, res_valid}, {32'h000C_0010, 2'b01});
        // Undefined code: no pulse, no flag, result left as it was
        issue(slu_op_t'(3'h6), 32'hFFFF_FFFF, 32'hFFFF_FFFF, 4'hF, 2'h0);
        check("unknown op", {res_valid, acc_done, ovf_set, result}, {3'b000, 32'h000C_0010});
    endtask : test_back_to_back

    // Main sequence after three cycles of reset
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        test_reset();
        test_half();
        test_byte();
        test_accum();
        test_sticky();
        test_back_to_back();
        results();
    end

    // Watchdog well beyond the roughly 490 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        results();
    end
endmodule : testbench
